/* common/hcir_pkg.sv */
// package: offsets, field positions, reset values and types of the host register block
`default_nettype none
package hcir_pkg;
    localparam logic [7:0] VER_OFS = 8'h00;
    localparam logic [7:0] ROM_OFS = 8'h04;
    localparam logic [7:0] RTY_OFS = 8'h08;
    localparam logic [7:0] MAJOR_VER = 8'h01;
    localparam logic [7:0] MINOR_VER = 8'h10;
    localparam int PRESENT_BIT = 24;
    localparam int CLEAR_BIT = 31;
    localparam int GO_BIT = 25;
    localparam int RDATA_LSB = 16;
    localparam int LIMIT_LSB = 0;
    localparam logic [7:0] SMALL_ROM_RST = 8'h00;
    localparam logic [7:0] SMALL_ROM_ADDR = 8'h28;
    localparam logic [7:0] BUSINFO_BASE = 8'h00;
    localparam logic [3:0] BUSINFO_BYTES = 4'h8;
    localparam logic [2:0] SETTLE_CYCLES = 3'h6;
    localparam logic [3:0] RETRY_RST = 4'h0;
    localparam logic [2:0] FILT_RST = 3'h3;
    localparam logic [8:0] SYNC_RST = 9'h03f;
    localparam int UNIT_REQ = 0;
    localparam int UNIT_ARESP = 1;
    localparam int UNIT_PRESP = 2;

    typedef enum logic [3:0] {
        HCIR_IDLE = 4'h1,
        HCIR_SETTLE = 4'h2,
        HCIR_BOOT = 4'h4,
        HCIR_READ = 4'h8
    } hcir_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } hcir_bus_t;

    typedef struct packed {
        logic req;
        logic [7:0] addr;
    } hcir_rom_req_t;

    typedef struct packed {
        logic ack_valid;
        logic ack_retry;
    } hcir_ack_t;

    typedef struct packed {
        logic resend;
        logic final_done;
        logic final_fail;
    } hcir_tx_rsp_t;

    typedef struct packed {
        hcir_state_t fsm;
        logic [2:0] settle;
        logic [3:0] boot_idx;
        logic present;
        logic clear_go;
        logic read_go;
        logic [7:0] rom_addr;
        logic [7:0] rom_byte;
        logic [7:0] small_rom;
        logic [7:0][7:0] bus_info;
        logic [2:0][3:0] lim;
        logic [2:0][3:0] cnt;
        hcir_tx_rsp_t [2:0] tx;
        logic [31:0] rdata;
        hcir_rom_req_t rom;
        logic [2:0][2:0] pin_sync;
        logic [2:0] filt;
    } hcir_regs_t;
endpackage
`default_nettype wire

/* hdl/hcir_regs.sv */
// module: version, eeprom access and transmit retry registers
//
// Operation
// - version bits 31-25 read zero
// - bit 24 flags a detected eeprom
// - present eeprom loads bus info after reset
// - major version field reads 01h
// - minor version field reads 10h
// - either reset pin restores defaults
// - bit 31 zeroes address, hardware clears it
// - address clear leaves read byte unchanged
// - bit 25 starts byte read, self-clears
// - fetched byte lands in bits 23-16
// - small rom offset loads from 28h
// - access port reserved bits read zero
// - dual-phase seconds field reads zero
// - dual-phase cycles field reads zero
// - physical response resends up to limit
// - async response resends up to limit
// - async request resends up to limit
// - retry bits 15-12 read zero
`timescale 1ns/1ps
`default_nettype none
module hcir_regs (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic fundamental_reset_pin_n_in,
    input wire logic global_reset_pin_n_in,
    input wire logic eeprom_detect_in,
    input wire hcir_pkg::hcir_bus_t bus_in,
    output logic [31:0] rdata_out,
    output hcir_pkg::hcir_rom_req_t rom_req_out,
    input wire logic rom_done_in,
    input wire logic [7:0] rom_data_in,
    output logic [63:0] bus_info_out,
    output logic eeprom_present_flag_out,
    output logic [7:0] small_rom_offset_out,
    input wire hcir_pkg::hcir_ack_t [2:0] tx_ack_in,
    output hcir_pkg::hcir_tx_rsp_t [2:0] tx_rsp_out
);

    hcir_pkg::hcir_regs_t q;
    hcir_pkg::hcir_regs_t d;

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic [31:0] reg_word(input logic [7:0] a,
                                             input hcir_pkg::hcir_regs_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (hit(a, hcir_pkg::VER_OFS)) begin
            w = {7'h00, s.present, hcir_pkg::MAJOR_VER, 8'h00, hcir_pkg::MINOR_VER};
        end else if (hit(a, hcir_pkg::ROM_OFS)) begin
            w = {s.clear_go, 5'h00, s.read_go, 1'b0, s.rom_byte, 8'h00, s.small_rom};
        end else if (hit(a, hcir_pkg::RTY_OFS)) begin
            w = {3'h0, 13'h0000, 4'h0, s.lim};
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [2:0][2:0] sync_keep;
        logic [2:0] filt_keep;
        logic [2:0] pins;
        sync_keep = '0;
        filt_keep = '0;
        pins = {eeprom_detect_in, global_reset_pin_n_in, fundamental_reset_pin_n_in};
        d = q;
        d.tx = '0;
        d.rdata = 32'h0000_0000;
        // pin synchronisers, level taken when second and third stage agree
        for (int p = 0; p < 3; p++) begin
            d.pin_sync[p] = {q.pin_sync[p][1:0], pins[p]};
            if (q.pin_sync[p][1] == q.pin_sync[p][2]) begin
                d.filt[p] = q.pin_sync[p][2];
            end
        end
        if (bus_in.rd) begin
            d.rdata = reg_word(bus_in.addr, q);
        end
        unique case (q.fsm)
            hcir_pkg::HCIR_SETTLE: begin
                d.settle = q.settle + 3'h1;
                if (q.settle == hcir_pkg::SETTLE_CYCLES - 3'h1) begin
                    d.present = q.filt[2];
                    if (q.filt[2]) begin
                        d.boot_idx = 4'h0;
                        d.rom.req = 1'b1;
                        d.rom.addr = hcir_pkg::BUSINFO_BASE;
                        d.fsm = hcir_pkg::HCIR_BOOT;
                    end else begin
                        d.fsm = hcir_pkg::HCIR_IDLE;
                    end
                end
            end
            hcir_pkg::HCIR_BOOT: begin
                if (rom_done_in) begin
                    if (q.boot_idx == hcir_pkg::BUSINFO_BYTES) begin
                        d.small_rom = rom_data_in;
                        d.rom.req = 1'b0;
                        d.fsm = hcir_pkg::HCIR_IDLE;
                    end else begin
                        d.bus_info[q.boot_idx[2:0]] = rom_data_in;
                        d.boot_idx = q.boot_idx + 4'h1;
                        if (q.boot_idx == hcir_pkg::BUSINFO_BYTES - 4'h1) begin
                            d.rom.addr = hcir_pkg::SMALL_ROM_ADDR;
                        end else begin
                            d.rom.addr = hcir_pkg::BUSINFO_BASE + {4'h0, q.boot_idx} + 8'h01;
                        end
                    end
                end
            end
            hcir_pkg::HCIR_IDLE: begin
                if (q.clear_go) begin
                    d.rom_addr = 8'h00;
                    d.clear_go = 1'b0;
                end else if (q.read_go) begin
                    d.rom.req = 1'b1;
                    d.rom.addr = q.rom_addr;
                    d.fsm = hcir_pkg::HCIR_READ;
                end
            end
            hcir_pkg::HCIR_READ: begin
                if (rom_done_in) begin
                    d.rom.req = 1'b0;
                    d.rom_byte = rom_data_in;
                    d.rom_addr = q.rom_addr + 8'h01;
                    d.read_go = 1'b0;
                    d.fsm = hcir_pkg::HCIR_IDLE;
                end
            end
        endcase
        // retry bookkeeping per transmit unit
        for (int u = 0; u < 3; u++) begin
            if (tx_ack_in[u].ack_valid) begin
                if (tx_ack_in[u].ack_retry && (q.cnt[u] < q.lim[u])) begin
                    d.cnt[u] = q.cnt[u] + 4'h1;
                    d.tx[u].resend = 1'b1;
                end else begin
                    d.cnt[u] = 4'h0;
                    d.tx[u].final_done = 1'b1;
                    d.tx[u].final_fail = tx_ack_in[u].ack_retry;
                end
            end
        end
        // software writes; a set beats the hardware clear of the same cycle
        if (bus_in.wr && hit(bus_in.addr, hcir_pkg::ROM_OFS)) begin
            if (bus_in.wdata[hcir_pkg::CLEAR_BIT]) begin
                d.clear_go = 1'b1;
            end
            if (bus_in.wdata[hcir_pkg::GO_BIT]) begin
                d.read_go = 1'b1;
            end
        end
        if (bus_in.wr && hit(bus_in.addr, hcir_pkg::RTY_OFS)) begin
            d.lim = bus_in.wdata[hcir_pkg::LIMIT_LSB +: 12];
        end
        // reset by rst_in, or by either filtered reset pin
        if (rst_in || !q.filt[0] || !q.filt[1]) begin
            sync_keep = d.pin_sync;
            filt_keep = d.filt;
            d = '0;
            d.fsm = hcir_pkg::HCIR_SETTLE;
            d.small_rom = hcir_pkg::SMALL_ROM_RST;
            d.lim = {3{hcir_pkg::RETRY_RST}};
            d.pin_sync = hcir_pkg::SYNC_RST;
            d.filt = hcir_pkg::FILT_RST;
            if (!rst_in) begin
                d.pin_sync = sync_keep;
                d.filt = filt_keep;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        q <= d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rdata_out = q.rdata;
    assign rom_req_out = q.rom;
    assign bus_info_out = q.bus_info;
    assign eeprom_present_flag_out = q.present;
    assign small_rom_offset_out = q.small_rom;
    assign tx_rsp_out = q.tx;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    logic rd_ver;
    logic rd_rom;
    logic rd_rty;
    logic idle_s;
    assign rd_ver = bus_in.rd && hit(bus_in.addr, hcir_pkg::VER_OFS);
    assign rd_rom = bus_in.rd && hit(bus_in.addr, hcir_pkg::ROM_OFS);
    assign rd_rty = bus_in.rd && hit(bus_in.addr, hcir_pkg::RTY_OFS);
    assign idle_s = q.fsm == hcir_pkg::HCIR_IDLE;

    ver_rsvd_a: assert property (rd_ver |=> rdata_out[31:25] == 7'h00)
        else $error("version reserved bits not zero");
    present_rd_a: assert property (rd_ver ##1 !$changed(q.present) |->
        rdata_out[24] == eeprom_present_flag_out)
        else $error("present flag misread");
    boot_start_a: assert property (q.fsm == hcir_pkg::HCIR_SETTLE &&
        q.settle == (hcir_pkg::SETTLE_CYCLES - 3'h1) && q.filt[2] |=>
        q.fsm == hcir_pkg::HCIR_BOOT && rom_req_out.req)
        else $error("boot load did not start");
    ver_major_a: assert property (rd_ver |=> rdata_out[23:16] == 8'h01)
        else $error("major version wrong");
    ver_minor_a: assert property (rd_ver |=> rdata_out[15:0] == 16'h0010)
        else $error("minor version wrong");
    pin_reset_a: assert property (!q.filt[0] || !q.filt[1] |=>
        !eeprom_present_flag_out && q.fsm == hcir_pkg::HCIR_SETTLE)
        else $error("pin reset ignored");
    addr_clear_a: assert property (idle_s && q.clear_go |=> q.rom_addr == 8'h00)
        else $error("address clear failed");
    clear_keep_a: assert property (idle_s && q.clear_go |=> $stable(q.rom_byte))
        else $error("address clear touched read byte");
    read_go_a: assert property (idle_s && !q.clear_go && q.read_go |=>
        rom_req_out.req && rom_req_out.addr == $past(q.rom_addr) ##1 q.read_go)
        else $error("read start not issued");
    read_byte_a: assert property (q.fsm == hcir_pkg::HCIR_READ && rom_done_in |=>
        q.rom_byte == $past(rom_data_in) && !rom_req_out.req)
        else $error("read byte not stored");
    small_rom_a: assert property (q.fsm == hcir_pkg::HCIR_BOOT && rom_done_in &&
        q.boot_idx == 4'h8 |=> small_rom_offset_out == $past(rom_data_in))
        else $error("small rom offset not loaded");
    rom_rsvd_a: assert property (rd_rom |=> rdata_out[30:26] == 5'h00 &&
        !rdata_out[24] && rdata_out[15:8] == 8'h00)
        else $error("access port reserved bits set");
    dp_seconds_a: assert property (rd_rty |=> rdata_out[31:29] == 3'h0)
        else $error("dual-phase seconds not zero");
    dp_cycles_a: assert property (rd_rty |=> rdata_out[28:16] == 13'h0000)
        else $error("dual-phase cycles not zero");
    rty_rsvd_a: assert property (rd_rty |=> rdata_out[15:12] == 4'h0)
        else $error("retry reserved bits set");
    phys_retry_a: assert property (tx_ack_in[2].ack_valid && tx_ack_in[2].ack_retry &&
        q.cnt[2] < q.lim[2] |=> tx_rsp_out[2].resend && !tx_rsp_out[2].final_done)
        else $error("physical response resend missing");
    aresp_retry_a: assert property (tx_ack_in[1].ack_valid && tx_ack_in[1].ack_retry &&
        q.cnt[1] < q.lim[1] |=> tx_rsp_out[1].resend)
        else $error("async response resend missing");
    areq_retry_a: assert property (tx_ack_in[0].ack_valid && tx_ack_in[0].ack_retry &&
        q.cnt[0] < q.lim[0] |=> tx_rsp_out[0].resend && q.cnt[0] == $past(q.cnt[0]) + 4'h1)
        else $error("async request resend missing");
    addr_step_a: assert property (q.fsm == hcir_pkg::HCIR_READ && rom_done_in |=>
        q.rom_addr == $past(q.rom_addr) + 8'h01)
        else $error("address did not advance");
    retry_done_a: assert property (tx_ack_in[0].ack_valid && tx_ack_in[0].ack_retry &&
        q.cnt[0] >= q.lim[0] |=> tx_rsp_out[0].final_done && tx_rsp_out[0].final_fail
        && q.cnt[0] == 4'h0)
        else $error("exhausted retry not reported");

    ////////////////////////////////////////////////////////////////////////////////
    // further checks on read data, handshakes and boot fill

    rdata_zero_a: assert property (!bus_in.rd |=> rdata_out == 32'h0000_0000)
        else $error("read data not zero outside a read");
    clear_done_a: assert property (idle_s && q.clear_go &&
        !(bus_in.wr && hit(bus_in.addr, hcir_pkg::ROM_OFS) && bus_in.wdata[31]) |=>
        !q.clear_go)
        else $error("address clear bit not cleared");
    read_done_a: assert property (q.fsm == hcir_pkg::HCIR_READ && rom_done_in &&
        !(bus_in.wr && hit(bus_in.addr, hcir_pkg::ROM_OFS) && bus_in.wdata[25]) |=>
        !q.read_go && idle_s)
        else $error("read start bit not cleared");
    idle_quiet_a: assert property (idle_s && !q.read_go |-> !rom_req_out.req)
        else $error("fetch request while idle");
    settle_quiet_a: assert property (q.fsm == hcir_pkg::HCIR_SETTLE |->
        !rom_req_out.req)
        else $error("fetch request during settle");
    boot_fill_a: assert property (q.fsm == hcir_pkg::HCIR_BOOT && rom_done_in &&
        q.boot_idx < 4'h8 |=> q.bus_info[$past(q.boot_idx[2:0])] == $past(rom_data_in))
        else $error("bus info byte not stored");
    boot_addr_a: assert property (q.fsm == hcir_pkg::HCIR_BOOT && rom_done_in &&
        q.boot_idx == 4'h7 |=> rom_req_out.req && rom_req_out.addr == 8'h28)
        else $error("small rom fetch address wrong");
    present_hold_a: assert property (idle_s && $past(idle_s) |->
        $stable(eeprom_present_flag_out))
        else $error("present flag changed outside settle");
    lim_write_a: assert property (bus_in.wr && hit(bus_in.addr, hcir_pkg::RTY_OFS) |=>
        q.lim == $past(bus_in.wdata[11:0]))
        else $error("retry limits not written");
    aresp_done_a: assert property (tx_ack_in[1].ack_valid &&
        (!tx_ack_in[1].ack_retry || q.cnt[1] >= q.lim[1]) |=>
        tx_rsp_out[1].final_done && !tx_rsp_out[1].resend && q.cnt[1] == 4'h0)
        else $error("async response final status missing");
    phys_done_a: assert property (tx_ack_in[2].ack_valid &&
        (!tx_ack_in[2].ack_retry || q.cnt[2] >= q.lim[2]) |=>
        tx_rsp_out[2].final_done && !tx_rsp_out[2].resend && q.cnt[2] == 4'h0)
        else $error("physical response final status missing");

    boot_done_c: cover property (q.fsm == hcir_pkg::HCIR_BOOT ##1 idle_s && q.present);
    sw_read_c: cover property (q.fsm == hcir_pkg::HCIR_READ ##1 idle_s ##[1:20] rd_rom);
    retry_out_c: cover property (tx_rsp_out[0].resend ##[1:50] tx_rsp_out[0].final_fail);
    clear_c: cover property (idle_s && q.clear_go && q.read_go);

endmodule
`default_nettype wire

/* sim/hcir_eeprom_model.sv */
// serial identity eeprom stand-in answering byte fetches
`timescale 1ns/1ps
`default_nettype none
module hcir_eeprom_model (
    input wire logic mclk_in,
    input wire hcir_pkg::hcir_rom_req_t rom_req_in,
    output logic rom_done_out,
    output logic [7:0] rom_data_out
);
    logic [2:0] wait_q = 3'h0;
    logic slow_q = 1'b0;
    logic [7:0] last_q = 8'h00;
    initial rom_done_out = 1'b0;
    initial rom_data_out = 8'h00;
    ////////////////////////////////////////
    // alternates prompt and slow answers; the data line shows no stale byte between fetches
    always @(posedge mclk_in) begin
        rom_done_out <= 1'b0;
        rom_data_out <= ~last_q;
        if (rom_req_in.req && !rom_done_out) begin
            if (wait_q == 3'h0) begin
                rom_done_out <= 1'b1;
                rom_data_out <= rom_req_in.addr * 8'h1d + 8'h07;
                last_q <= rom_req_in.addr * 8'h1d + 8'h07;
                slow_q <= ~slow_q;
                wait_q <= slow_q ? 3'h1 : 3'h5;
            end else begin
                wait_q <= wait_q - 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench of the version, eeprom access and retry registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("CHECK FAILED %0t %s", $time, m); \
    end \
end
module testbench;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [1:0] pin_n = 2'b11;
    logic detect = 1'b1;
    hcir_pkg::hcir_bus_t bus = '0;
    hcir_pkg::hcir_ack_t [2:0] ack = '0;
    logic rom_done;
    logic [7:0] rom_data;
    logic [31:0] rdata;
    hcir_pkg::hcir_rom_req_t rom_req;
    logic [63:0] bus_info;
    logic present;
    logic [7:0] small_rom;
    hcir_pkg::hcir_tx_rsp_t [2:0] rsp;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [15:0] lfsr = 16'h5027;
    int lim[3] = '{0, 0, 0};
    int cnt[3] = '{0, 0, 0};
    logic [31:0] d;
    logic [31:0] w;

    initial begin
        forever #12.5 mclk_in = ~mclk_in;
    end

    hcir_regs dut (.mclk_in(mclk_in), .rst_in(rst_in), .fundamental_reset_pin_n_in(pin_n[0]),
        .global_reset_pin_n_in(pin_n[1]), .eeprom_detect_in(detect), .bus_in(bus),
        .rdata_out(rdata), .rom_req_out(rom_req), .rom_done_in(rom_done),
        .rom_data_in(rom_data), .bus_info_out(bus_info), .eeprom_present_flag_out(present),
        .small_rom_offset_out(small_rom), .tx_ack_in(ack), .tx_rsp_out(rsp));
    hcir_eeprom_model eeprom (.mclk_in(mclk_in), .rom_req_in(rom_req),
        .rom_done_out(rom_done), .rom_data_out(rom_data));

    ////////////////////////////////////////
    function automatic logic [7:0] rom_byte(input logic [7:0] a);
        return a * 8'h1d + 8'h07;
    endfunction

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic give_verdict();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_in);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge mclk_in);
        bus.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk_in);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge mclk_in);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic wait_req(input logic lvl);
        #1;
        for (int i = 0; i < 300 && rom_req.req !== lvl; i++) begin
            @(posedge mclk_in);
            #1;
        end
        if (rom_req.req !== lvl) begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    // model: resend while retries remain, else final status and count back to zero
    task automatic send_ack(input int u, input logic r);
        logic [2:0] e;
        if (r && cnt[u] < lim[u]) begin
            e = 3'b100;
            cnt[u]++;
        end else begin
            e = {2'b01, r};
            cnt[u] = 0;
        end
        @(posedge mclk_in);
        ack[u] <= '{ack_valid: 1'b1, ack_retry: r};
        @(posedge mclk_in);
        ack[u] <= '0;
        #1 `CHK(rsp[u], e, "retry response")
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        wait_req(1'b1);
        `CHK(rom_req.addr, 8'h00, "boot start")
        wait_req(1'b0);
        for (int k = 0; k < 8; k++) `CHK(bus_info[8*k +: 8], rom_byte(8'(k)), "bus info")
        `CHK(small_rom, rom_byte(8'h28), "small rom")
        `CHK(small_rom > 8'h39, 1'b1, "small rom offset not valid")
        `CHK(present, 1'b1, "port used without eeprom")
        reg_wr(8'h00, 32'hffffffff);
        reg_rd(8'h00, d);
        w = {7'h00, 1'b1, hcir_pkg::MAJOR_VER, 8'h00, hcir_pkg::MINOR_VER};
        `CHK(d, w, "version")
        reg_rd(8'h0c, d);
        `CHK(d, 32'h0, "unmapped")
        reg_wr(8'h04, 32'hfdffffff);
        reg_rd(8'h04, d);
        `CHK(d, {24'h0, rom_byte(8'h28)}, "address clear")
        for (int k = 0; k < 3; k++) begin
            reg_wr(8'h04, k == 2 ? 32'h82000000 : 32'h02000000);
            wait_req(1'b1);
            `CHK(rom_req.addr, k == 2 ? 8'h00 : 8'(k), "fetch address")
            wait_req(1'b0);
            reg_rd(8'h04, d);
            w = {8'h00, rom_byte(k == 2 ? 8'h00 : 8'(k)), 8'h00, rom_byte(8'h28)};
            `CHK(d, w, "read byte")
        end
        send_ack(2, 1'b1);
        lfsr = lfsr_next(lfsr);
        w[31:16] = lfsr;
        lfsr = lfsr_next(lfsr);
        w[15:0] = lfsr;
        reg_wr(8'h08, w);
        for (int u = 0; u < 3; u++) lim[u] = w[4*u +: 4];
        reg_rd(8'h08, d);
        `CHK(d, w & 32'h00000fff, "retry limits")
        for (int u = 0; u < 3; u++) begin
            for (int n = 0; n < 20; n++) begin
                lfsr = lfsr_next(lfsr);
                send_ack(u, lfsr[0] | lfsr[1]);
            end
        end
        detect <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            reg_wr(8'h08, 32'h00000fff);
            @(posedge mclk_in);
            pin_n[p] <= 1'b0;
            repeat (6) @(posedge mclk_in);
            pin_n[p] <= 1'b1;
            repeat (12) @(posedge mclk_in);
            #1 `CHK({present, small_rom}, 9'h000, "pin reset")
            reg_rd(8'h00, d);
            w = {8'h00, hcir_pkg::MAJOR_VER, 8'h00, hcir_pkg::MINOR_VER};
            `CHK(d, w, "version default")
            reg_rd(8'h08, d);
            `CHK(d, 32'h0, "retry default")
        end
        give_verdict();
    end

    initial begin
        #2000000;
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
